/* design/bse_pkg.sv */
// Register map, field positions and counts of the error cause block
package bse_pkg;

	// Printed offsets are register indexes; byte address is four times
	localparam logic [9:0] BSE_IDX_DISABLE = 10'h064;
	localparam logic [9:0] BSE_IDX_STATUS  = 10'h06A;
	localparam logic [9:0] BSE_IDX_CTRL    = 10'h06C;
	localparam logic [9:0] BSE_IDX_IEN     = 10'h06D;

	localparam int BSE_ADDR_W   = 12;
	localparam int BSE_NFLAG    = 8;
	localparam int BSE_CTR_LOG2 = 24;

	// Cause bit positions
	localparam int BSE_B_ADDR_PAR = 0;
	localparam int BSE_B_PW_PAR   = 1;
	localparam int BSE_B_PW_NDLV  = 2;
	localparam int BSE_B_PW_TABT  = 3;
	localparam int BSE_B_PW_MABT  = 4;
	localparam int BSE_B_DW_NDLV  = 5;
	localparam int BSE_B_DR_NODAT = 6;
	localparam int BSE_B_DT_TMO   = 7;
	localparam int BSE_B_SERR_EN  = 0;

	// Reset values and writable masks
	localparam logic [7:0] BSE_RST_STATUS = 8'h00;
	localparam logic [7:0] BSE_RST_DIS    = 8'h00;
	localparam logic [7:0] BSE_RST_IEN    = 8'h00;
	localparam logic [7:0] BSE_DIS_WMASK  = 8'h7E;
	localparam logic [31:0] BSE_RD_ZERO   = 32'h0000_0000;

endpackage

/* design/bse_attempt_ctr.sv */
// Delivery attempt counter for one queued transaction
`timescale 1ns/1ps
`default_nettype none
module bse_attempt_ctr
	import bse_pkg::*;
#(
	parameter int CW = BSE_CTR_LOG2
)(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Queue activity
	input  wire logic attempt,
	input  wire logic done,
	// Limit reached without success
	output logic      fail
);

	if (CW < 1 || CW > 31) begin : g_chk
		$error("bse_attempt_ctr: CW must be 1 to 31");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
	} bse_ctr_t;

	bse_ctr_t s_r;
	bse_ctr_t s_nxt;

	// Last attempt that still fails completes the full count
	assign fail = attempt && !done && (&s_r.cnt);

	always_comb begin
		s_nxt = s_r;
		if (done || fail) begin
			s_nxt.cnt = '0;
		end else if (attempt) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	ctr_fail_max_a: assert property (@(posedge pclk) disable iff (!presetn)
		fail |=> (s_r.cnt == '0))
		else $error("counter not restarted after failure");

endmodule
`default_nettype wire

/* design/bse_sticky_flags.sv */
// Sticky cause flags, set by hardware, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module bse_sticky_flags
	import bse_pkg::*;
#(
	parameter int W = BSE_NFLAG
)(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Set and clear vectors
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// Flag state
	output logic      [W-1:0] flags
);

	if (W < 1 || W > 32) begin : g_chk
		$error("bse_sticky_flags: W must be 1 to 32");
	end

	typedef struct packed {
		logic [W-1:0] q;
	} bse_flag_t;

	bse_flag_t s_r;
	bse_flag_t s_nxt;

	assign flags = s_r.q;

	// Set wins over a clear in the same cycle
	always_comb begin
		s_nxt   = s_r;
		s_nxt.q = (s_r.q & ~clr) | set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	flag_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(set != '0) |=> ((s_r.q & $past(set)) == $past(set)))
		else $error("set flag lost");

endmodule
`default_nettype wire

/* design/bse_serr_cause.sv */
// System error cause status block with APB register access
// Notes on behaviour
// - A status register shows which cause drove the system error output.
// - Bit 0 records an address parity error on either bus, W1C, reset 0.
// - Bit 1 records a posted write data parity error, W1C, reset 0.
// - Bit 2 records posted write data not delivered in 2^24 tries.
// - Bit 3 records a target abort while delivering posted write data.
// - Bit 4 records a master abort while delivering posted write data.
// - Bit 5 records delayed write data not delivered in 2^24 tries.
// - Bit 6 records a delayed read getting no data in 2^24 tries.
// - Bit 7 records an initiator not repeating a delayed transaction.
// - An event drives the output only if not disabled and enable is set.
`timescale 1ns/1ps
`default_nettype none
module bse_serr_cause
	import bse_pkg::*;
#(
	parameter int ATTEMPT_LOG2 = BSE_CTR_LOG2
)(
	// APB clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [BSE_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	// Error events, one-cycle pulses
	input  wire logic                  addr_par_err,
	input  wire logic                  pw_par_err,
	input  wire logic                  pw_tgt_abort,
	input  wire logic                  pw_mst_abort,
	input  wire logic                  dt_mst_timeout,
	// Queue delivery activity
	input  wire logic                  pw_attempt,
	input  wire logic                  pw_done,
	input  wire logic                  dw_attempt,
	input  wire logic                  dw_done,
	input  wire logic                  dr_attempt,
	input  wire logic                  dr_done,
	// System error output and interrupt
	output logic                       sys_err_n,
	output logic                       irq
);

	if (ATTEMPT_LOG2 < 1 || ATTEMPT_LOG2 > 31) begin : g_chk
		$error("bse_serr_cause: ATTEMPT_LOG2 must be 1 to 31");
	end

	typedef struct packed {
		logic [7:0]  dis;
		logic        serr_en;
		logic [7:0]  ien;
		logic        serr;
		logic [31:0] rdata;
		logic        slverr;
	} bse_main_t;

	bse_main_t s_r;
	bse_main_t s_nxt;

	logic [7:0] status;
	logic [7:0] evt;
	logic [7:0] fire;
	logic [7:0] w1c;
	logic       pw_fail;
	logic       dw_fail;
	logic       dr_fail;
	logic       setup;
	logic       wr_acc;
	logic [9:0] idx;
	logic       hit;

	// Nondelivery counters per queue
	bse_attempt_ctr #(.CW(ATTEMPT_LOG2)) u_pw_ctr (
		.pclk    (pclk),
		.presetn (presetn),
		.attempt (pw_attempt),
		.done    (pw_done),
		.fail    (pw_fail)
	);

	bse_attempt_ctr #(.CW(ATTEMPT_LOG2)) u_dw_ctr (
		.pclk    (pclk),
		.presetn (presetn),
		.attempt (dw_attempt),
		.done    (dw_done),
		.fail    (dw_fail)
	);

	bse_attempt_ctr #(.CW(ATTEMPT_LOG2)) u_dr_ctr (
		.pclk    (pclk),
		.presetn (presetn),
		.attempt (dr_attempt),
		.done    (dr_done),
		.fail    (dr_fail)
	);

	always_comb begin
		evt                 = '0;
		evt[BSE_B_ADDR_PAR] = addr_par_err;
		evt[BSE_B_PW_PAR]   = pw_par_err;
		evt[BSE_B_PW_NDLV]  = pw_fail;
		evt[BSE_B_PW_TABT]  = pw_tgt_abort;
		evt[BSE_B_PW_MABT]  = pw_mst_abort;
		evt[BSE_B_DW_NDLV]  = dw_fail;
		evt[BSE_B_DR_NODAT] = dr_fail;
		evt[BSE_B_DT_TMO]   = dt_mst_timeout;
	end

	// Bits 0 and 7 have no disable; their disable bits never store
	assign fire = evt & ~s_r.dis & {8{s_r.serr_en}};

	// APB decode; zero wait states, data captured at setup
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pstrb[0];
	assign idx    = paddr[11:2];
	assign hit    = (paddr[1:0] == 2'b00) &&
		(idx == BSE_IDX_DISABLE || idx == BSE_IDX_STATUS ||
		 idx == BSE_IDX_CTRL || idx == BSE_IDX_IEN);
	assign w1c    = (wr_acc && !s_r.slverr && idx == BSE_IDX_STATUS) ?
		pwdata[7:0] : 8'h00;

	// Flags set on the same edge that raises the output
	bse_sticky_flags #(.W(BSE_NFLAG)) u_flags (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (fire),
		.clr     (w1c),
		.flags   (status)
	);

	always_comb begin
		s_nxt      = s_r;
		s_nxt.serr = |fire;
		if (setup) begin
			s_nxt.slverr = !hit;
			s_nxt.rdata  = BSE_RD_ZERO;
			unique case (idx)
				BSE_IDX_DISABLE: s_nxt.rdata[7:0] = s_r.dis;
				BSE_IDX_STATUS:  s_nxt.rdata[7:0] = status;
				BSE_IDX_CTRL:    s_nxt.rdata[BSE_B_SERR_EN] = s_r.serr_en;
				BSE_IDX_IEN:     s_nxt.rdata[7:0] = s_r.ien;
				default:         s_nxt.rdata = BSE_RD_ZERO;
			endcase
		end
		if (wr_acc && !s_r.slverr) begin
			unique case (idx)
				BSE_IDX_DISABLE: s_nxt.dis = pwdata[7:0] & BSE_DIS_WMASK;
				BSE_IDX_CTRL:    s_nxt.serr_en = pwdata[BSE_B_SERR_EN];
				BSE_IDX_IEN:     s_nxt.ien = pwdata[7:0];
				default:         s_nxt.ien = s_r.ien;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.dis     <= BSE_RST_DIS;
			s_r.serr_en <= 1'b0;
			s_r.ien     <= BSE_RST_IEN;
			s_r.serr    <= 1'b0;
			s_r.rdata   <= BSE_RD_ZERO;
			s_r.slverr  <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready    = 1'b1;
	assign prdata    = s_r.rdata;
	assign pslverr   = psel && penable && s_r.slverr;
	assign sys_err_n = !s_r.serr;
	// Level interrupt while any enabled flag stands
	assign irq       = |(status & s_r.ien);

	sequence unmapped_setup_s;
		psel && !penable && !hit;
	endsequence

	sequence access_err_s;
		psel && penable && pslverr;
	endsequence

	serr_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fire != 8'h00) |=> !sys_err_n)
		else $error("system error not driven after event");

	serr_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		!sys_err_n |-> ($past(fire) != 8'h00 && $past(s_r.serr_en)))
		else $error("system error driven without enabled cause");

	flag_with_serr_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(!sys_err_n) |-> ((status & $past(fire)) != 8'h00))
		else $error("flag not set with system error");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(($past(status) & ~status) != 8'h00) |->
		(($past(status) & ~status & $past(w1c)) ==
		 ($past(status) & ~status)))
		else $error("flag cleared without write of one");

	addr_par_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(addr_par_err && s_r.serr_en) |=> status[BSE_B_ADDR_PAR])
		else $error("address parity flag not set");

	timeout_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dt_mst_timeout && s_r.serr_en) |=> status[BSE_B_DT_TMO])
		else $error("time-out flag not set");

	pw_par_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pw_par_err && s_r.serr_en && !s_r.dis[BSE_B_PW_PAR])
		|=> status[BSE_B_PW_PAR] && !sys_err_n)
		else $error("posted write parity not reported");

	ndlv_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pw_fail && s_r.serr_en && !s_r.dis[BSE_B_PW_NDLV])
		|=> status[BSE_B_PW_NDLV])
		else $error("posted write nondelivery not flagged");

	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		unmapped_setup_s ##1 (psel && penable) |-> access_err_s)
		else $error("unmapped access not refused");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		((status & s_r.ien) != 8'h00) |-> irq ##1
		(irq || $past(w1c) != 8'h00 || $changed(s_r.ien)))
		else $error("interrupt dropped while flag enabled");

	sequence status_read_s;
		psel && !penable && !pwrite && hit && idx == BSE_IDX_STATUS;
	endsequence

	sequence strobed_access_s;
		psel && penable && pwrite && pstrb[0];
	endsequence

	sequence ctrl_setup_s;
		psel && !penable && pwrite && hit && idx == BSE_IDX_CTRL;
	endsequence

	sequence dis_setup_s;
		psel && !penable && pwrite && hit && idx == BSE_IDX_DISABLE;
	endsequence

	sequence ien_setup_s;
		psel && !penable && pwrite && hit && idx == BSE_IDX_IEN;
	endsequence

	pw_tabt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pw_tgt_abort && s_r.serr_en && !s_r.dis[BSE_B_PW_TABT])
		|=> status[BSE_B_PW_TABT])
		else $error("target abort not flagged");

	pw_mabt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pw_mst_abort && s_r.serr_en && !s_r.dis[BSE_B_PW_MABT])
		|=> status[BSE_B_PW_MABT])
		else $error("master abort not flagged");

	dw_ndlv_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dw_fail && s_r.serr_en && !s_r.dis[BSE_B_DW_NDLV])
		|=> status[BSE_B_DW_NDLV])
		else $error("delayed write nondelivery not flagged");

	dr_nodat_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dr_fail && s_r.serr_en && !s_r.dis[BSE_B_DR_NODAT])
		|=> status[BSE_B_DR_NODAT])
		else $error("delayed read starvation not flagged");

	// Read data is latched in setup, so it shows the flags of that edge
	status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		status_read_s ##1 (psel && penable)
		|-> (prdata[7:0] == $past(status)))
		else $error("status read does not show flags");

	quiet_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!s_r.serr_en |=> sys_err_n)
		else $error("system error driven while disabled");

	dis_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.dis & ~BSE_DIS_WMASK) == 8'h00)
		else $error("disable bit stored for a cause without one");

	flag_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		(status & ~$past(status) & ~$past(fire)) == 8'h00)
		else $error("flag set without its cause firing");

	w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(w1c != 8'h00) |=>
		((status & $past(w1c) & ~$past(fire)) == 8'h00))
		else $error("flag not cleared by write of one");

	serr_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fire == 8'h00) |=> sys_err_n)
		else $error("system error held without an event");

	ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_setup_s ##1 strobed_access_s
		|=> (s_r.serr_en == $past(pwdata[BSE_B_SERR_EN])))
		else $error("enable bit not written");

	dis_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		dis_setup_s ##1 strobed_access_s
		|=> (s_r.dis == ($past(pwdata[7:0]) & BSE_DIS_WMASK)))
		else $error("disable register not written");

	ien_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		ien_setup_s ##1 strobed_access_s
		|=> (s_r.ien == $past(pwdata[7:0])))
		else $error("interrupt enable not written");

	ien_no_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
		ien_setup_s ##1 (psel && penable && !pstrb[0])
		|=> $stable(s_r.ien))
		else $error("write without byte strobe took effect");

endmodule
`default_nettype wire

/* sim/bse_bus_partner.sv */
// Far side model: bus error events and queue delivery attempts
`timescale 1ns/1ps
`default_nettype none
module bse_bus_partner (
	// Clock
	input  wire logic       pclk,
	// Events and queue activity
	output logic      [4:0] ev,
	output logic      [2:0] att,
	output logic      [2:0] dn
);
	initial begin
		ev = '0;
		att = '0;
		dn = '0;
	end
	// One-cycle event pulse, bit 4 is the initiator time-out
	task automatic pulse(input logic [4:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= '0;
	endtask
	// Back-to-back attempts, last one succeeds if ok
	task automatic tries(input int q, input int n, input logic ok);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			att <= 3'b001 << q;
			dn <= (ok && i == n - 1) ? 3'b001 << q : 3'b000;
		end
		@(posedge pclk);
		att <= 3'b000;
		dn <= 3'b000;
	endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the system error cause block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bse_pkg::*;
	localparam int          LOG2 = 3;
	localparam int          LIM  = 1 << LOG2;
	localparam logic [11:0] A_DIS = {BSE_IDX_DISABLE, 2'b00};
	localparam logic [11:0] A_STS = {BSE_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_CTL = {BSE_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_IEN = {BSE_IDX_IEN, 2'b00};
	localparam int          QB [3] = '{BSE_B_PW_NDLV, BSE_B_DW_NDLV,
	                                   BSE_B_DR_NODAT};
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, sys_err_n, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, b;
	logic [3:0]  pstrb, strb;
	logic [4:0]  ev;
	logic [2:0]  att, dn;
	int          mismatches = 0;
	int          checks = 0;

	bse_bus_partner p (.pclk(pclk), .ev(ev), .att(att), .dn(dn));
	bse_serr_cause #(.ATTEMPT_LOG2(LOG2)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.addr_par_err(ev[0]), .pw_par_err(ev[1]), .pw_tgt_abort(ev[2]),
		.pw_mst_abort(ev[3]), .dt_mst_timeout(ev[4]),
		.pw_attempt(att[0]), .pw_done(dn[0]), .dw_attempt(att[1]),
		.dw_done(dn[1]), .dr_attempt(att[2]), .dr_done(dn[2]),
		.sys_err_n(sys_err_n), .irq(irq));

	always #2.5 pclk = ~pclk;

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
	                   input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= strb;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
		chk1(er, 1'b0);
	endtask
	// Pulse events, check output and flags, then clear by writing one
	task automatic fire(input logic [4:0] m, input logic [31:0] exp,
	                    input logic out_n);
		p.pulse(m);
		#1 chk1(sys_err_n, out_n);
		wr(A_STS, 32'h0000_0000);
		rdc(A_STS, exp);
		wr(A_STS, exp);
		rdc(A_STS, 32'h0000_0000);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		strb = 4'hF;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		#1 chk1(sys_err_n, 1'b1);
		chk1(irq, 1'b0);
		rdc(A_STS, 32'h0000_0000);
		rdc(A_DIS, 32'h0000_0000);
		rdc(A_IEN, 32'h0000_0000);
		fire(5'b11111, 32'h0000_0000, 1'b1);
		wr(A_CTL, 32'h0000_0001);
		rdc(A_CTL, 32'h0000_0001);
		fire(5'b00001, 32'h0000_0001, 1'b0);
		fire(5'b00010, 32'h0000_0002, 1'b0);
		fire(5'b00100, 32'h0000_0008, 1'b0);
		fire(5'b01000, 32'h0000_0010, 1'b0);
		fire(5'b10000, 32'h0000_0080, 1'b0);
		fire(5'b11111, 32'h0000_009B, 1'b0);
		wr(A_DIS, 32'hFFFF_FFFF);
		rdc(A_DIS, 32'h0000_007E);
		fire(5'b01110, 32'h0000_0000, 1'b1);
		fire(5'b10001, 32'h0000_0081, 1'b0);
		wr(A_DIS, 32'h0000_0000);
		for (int q = 0; q < 3; q++) begin
			b = 32'h0000_0001 << QB[q];
			p.tries(q, LIM - 1, 1'b0);
			rdc(A_STS, 32'h0000_0000);
			p.tries(q, 1, 1'b0);
			rdc(A_STS, b);
			wr(A_STS, b);
			p.tries(q, LIM - 1, 1'b0);
			p.tries(q, 1, 1'b1);
			p.tries(q, LIM - 1, 1'b0);
			rdc(A_STS, 32'h0000_0000);
			p.tries(q, 1, 1'b0);
			rdc(A_STS, b);
			wr(A_STS, b);
		end
		// Mask holds the flag but hides the interrupt
		wr(A_IEN, 32'h0000_0008);
		rdc(A_IEN, 32'h0000_0008);
		p.pulse(5'b00100);
		#1 chk1(irq, 1'b1);
		wr(A_IEN, 32'h0000_0000);
		#1 chk1(irq, 1'b0);
		wr(A_IEN, 32'h0000_0008);
		#1 chk1(irq, 1'b1);
		wr(A_STS, 32'h0000_0008);
		#1 chk1(irq, 1'b0);
		apb(1'b0, A_STS + 12'h004, 32'h0000_0000);
		chk1(er, 1'b1);
		chk(rd, 32'h0000_0000);
		apb(1'b1, A_IEN + 12'h001, 32'h0000_00FF);
		chk1(er, 1'b1);
		rdc(A_IEN, 32'h0000_0008);
		// Byte strobe off: write ignored without error
		strb = 4'hE;
		wr(A_IEN, 32'h0000_00FF);
		chk1(er, 1'b0);
		strb = 4'hF;
		rdc(A_IEN, 32'h0000_0008);
		// Reset in mid-run drops flags and enables
		p.pulse(5'b00001);
		rdc(A_STS, 32'h0000_0001);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(A_STS, 32'h0000_0000);
		rdc(A_CTL, 32'h0000_0000);
		tally_and_finish;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
